/* File: logic/qsd_pkg.sv */
package qsd_pkg;
  localparam int DW         = 32;
  localparam int AW         = 11;
  localparam int BW         = 2;
  localparam int NB         = 4;
  localparam int ROW_W      = 11;
  localparam int COL_W      = 8;
  localparam int LANES      = DW / 8;
  localparam int RAW        = 6;
  localparam int AP_BIT     = 10;
  // mode word fields
  localparam int MR_BL      = 0;
  localparam int MR_BT      = 3;
  localparam int MR_CL      = 4;
  localparam int MR_WB      = 9;
  localparam logic [2:0] BL_FULL = 3'h7;
  localparam logic [2:0] CL3     = 3'h3;
  localparam logic [AW-1:0] MODE_RST = 11'h020;
  // refresh pacing
  localparam int CLK_NS     = 4;
  localparam int REF_WIN_NS = 64_000_000;
  localparam int REF_OPS    = 4096;
  localparam int REF_IVL    = REF_WIN_NS / REF_OPS / CLK_NS;
  localparam int FIFO_DEPTH = 8;
  // controller registers
  localparam logic [RAW-1:0] REG_CTRL  = 6'h00;
  localparam logic [RAW-1:0] REG_CMD   = 6'h04;
  localparam logic [RAW-1:0] REG_ADDR  = 6'h08;
  localparam logic [RAW-1:0] REG_WDATA = 6'h0C;
  localparam logic [RAW-1:0] REG_RDATA = 6'h10;
  localparam logic [RAW-1:0] REG_STAT  = 6'h14;
  localparam int CT_CKE     = 0;
  localparam int CT_REFEN   = 1;
  localparam int CT_CL3     = 2;
  localparam int CT_MASK    = 4;
  localparam int CM_OP      = 0;
  localparam int CM_BEATS   = 4;
  localparam int AD_BANK    = 11;
  localparam int ST_BUSY    = 0;
  localparam int ST_PEND    = 1;
  localparam int ST_RCNT    = 8;
  localparam logic [DW-1:0] CTRL_RST = 32'h0000_0001;
  localparam logic [1:0] RESP_OK     = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    CMD_MRS = 3'h0,
    CMD_REF = 3'h1,
    CMD_PRE = 3'h2,
    CMD_ACT = 3'h3,
    CMD_WR  = 3'h4,
    CMD_RD  = 3'h5,
    CMD_BST = 3'h6,
    CMD_NOP = 3'h7
  } qsd_cmd_e;

  typedef enum logic [1:0] {
    PWR_RUN  = 2'h0,
    PWR_PDN  = 2'h1,
    PWR_SUSP = 2'h2,
    PWR_SREF = 2'h3
  } qsd_pwr_e;

  typedef enum logic [1:0] {
    PH_IDLE = 2'h0,
    PH_WR   = 2'h1,
    PH_RD   = 2'h2,
    PH_REF  = 2'h3
  } qsd_ph_e;
endpackage

/* File: logic/qsd_if.sv */
interface qsd_if;
  import qsd_pkg::*;
  logic             cke;
  logic             cs_n;
  logic             ras_n;
  logic             cas_n;
  logic             we_n;
  logic [BW-1:0]    bank_select;
  logic [AW-1:0]    address_bus;
  logic [LANES-1:0] byte_lane_mask;
  logic [DW-1:0]    dq_c;
  logic [LANES-1:0] dq_c_oe;
  logic [DW-1:0]    dq_d;
  logic [LANES-1:0] dq_d_oe;
  wire  [DW-1:0]    data_bus;

  for (genvar i = 0; i < LANES; i++) begin : g_lane
    // undriven lane shows the inverse of the last device word
    assign data_bus[8*i+:8] = dq_c_oe[i] ? dq_c[8*i+:8] : dq_d_oe[i] ? dq_d[8*i+:8] : ~dq_d[8*i+:8];
  end

  modport ctl (output cke, cs_n, ras_n, cas_n, we_n, bank_select, address_bus, byte_lane_mask,
               output dq_c, dq_c_oe, input data_bus);
  modport dev (input cke, cs_n, ras_n, cas_n, we_n, bank_select, address_bus, byte_lane_mask,
               output dq_d, dq_d_oe, input data_bus);
endinterface

/* File: logic/qsd_fifo.sv */
module qsd_fifo #(
  parameter int W = 32,
  parameter int D = 8
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  import qsd_pkg::*;
  localparam int PW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [PW-1:0]       wp;
    logic [PW-1:0]       rp;
    logic [PW:0]         cnt;
  } qsd_fifo_s;

  qsd_fifo_s s_r;
  qsd_fifo_s s_nxt;
  logic      push;
  logic      pop;

  assign in_ready  = (s_r.cnt != (PW+1)'(D));
  assign out_valid = (s_r.cnt != '0);
  assign out_data  = s_r.mem[s_r.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.mem[s_r.wp] = in_data;
      s_nxt.wp          = (s_r.wp == PW'(D - 1)) ? '0 : s_r.wp + 1'b1;
    end
    if (pop) begin
      s_nxt.rp = (s_r.rp == PW'(D - 1)) ? '0 : s_r.rp + 1'b1;
    end
    s_nxt.cnt = s_r.cnt + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule

/* File: logic/qsd_dev.sv */
// Behaviour
// - inputs and data captured on rising edge
// - four banks, 2048 rows, 256 columns, 32 bits
// - controller activates bank row before access
// - read or write starts at given column
// - burst 1,2,4,8 or full page, terminable
// - sequential or interleaved column order
// - read latency two or three cycles
// - controller issues 4096 refreshes per 64 ms
// - auto precharge closes row after burst
// - internal column stepping, new column any cycle
// - burst stop or bank precharge ends burst
// - burst reads with single-location writes mode
// - precharge one bank while another transfers
// - auto refresh, self refresh, power-down states
// - lane mask blocks writes, floats reads
// - low clock gate invalidates next edge
// - chip select high ignores commands
module qsd_dev #(
  parameter int ROWW = qsd_pkg::ROW_W,
  parameter int COLW = qsd_pkg::COL_W
) (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  qsd_if.dev                      bus,
  output qsd_pkg::qsd_pwr_e       pwr_state,
  output logic [qsd_pkg::NB-1:0]  bank_open
);
  import qsd_pkg::*;
  localparam int MA = BW + ROWW + COLW;

  typedef struct packed {
    logic                    cke_q;
    logic [AW-1:0]           mode;
    logic [NB-1:0]           open;
    logic [NB-1:0][ROWW-1:0] row;
    logic                    act;
    logic                    wr;
    logic                    ap;
    logic [BW-1:0]           bank;
    logic [COLW-1:0]         start;
    logic [COLW:0]           cnt;
    logic [1:0]              rv;
    logic [1:0][LANES-1:0]   rm;
    logic [1:0][MA-1:0]      ra;
    logic [LANES-1:0]        oe;
    qsd_pwr_e                pwr;
  } qsd_dev_s;

  localparam qsd_dev_s DEV_RST = '{cke_q: 1'b1, mode: MODE_RST, pwr: PWR_RUN, default: '0};

  qsd_dev_s         s_r;
  qsd_dev_s         s_nxt;
  logic [DW-1:0]    mem [2**MA];
  logic [DW-1:0]    dq_r;
  qsd_cmd_e         cmd;
  logic             full;
  logic             sel;
  logic             beat;
  logic             bw;
  logic             stop;
  logic [BW-1:0]    bbank;
  logic [COLW-1:0]  bcol;
  logic             bwr;
  logic [MA-1:0]    baddr;

  assign full = (s_r.mode[MR_BL+:3] == BL_FULL);
  assign sel  = (s_r.mode[MR_CL+:3] == CL3);

  function automatic logic [COLW:0] blen(input logic w);
    if (w && s_r.mode[MR_WB]) begin
      blen = (COLW+1)'(1);
    end else if (full) begin
      blen = (COLW+1)'(1) << COLW;
    end else begin
      blen = (COLW+1)'(1) << s_r.mode[MR_BL+:2];
    end
  endfunction

  function automatic logic [COLW-1:0] col_at(input logic [COLW-1:0] st, input logic [COLW:0] k);
    logic [COLW-1:0] m;
    m = COLW'(blen(1'b0) - 1'b1);
    if (full) begin
      col_at = st + k[COLW-1:0];
    end else if (s_r.mode[MR_BT]) begin
      col_at = st ^ (k[COLW-1:0] & m);
    end else begin
      col_at = (st & ~m) | ((st + k[COLW-1:0]) & m);
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_nxt       = s_r;
    cmd         = qsd_cmd_e'({bus.ras_n, bus.cas_n, bus.we_n});
    beat        = 1'b0;
    bw          = s_r.wr;
    stop        = 1'b0;
    bbank       = s_r.bank;
    bcol        = col_at(s_r.start, s_r.cnt);
    s_nxt.cke_q = bus.cke;
    if (!s_r.cke_q) begin
      // edge invalid: all frozen except power state and gate sample
      if (s_r.pwr != PWR_SREF) begin
        s_nxt.pwr = s_r.act ? PWR_SUSP : PWR_PDN;
      end
    end else begin
      s_nxt.pwr = PWR_RUN;
      s_nxt.rv  = {s_r.rv[0], 1'b0};
      s_nxt.rm  = {s_r.rm[0], LANES'(0)};
      s_nxt.ra  = {s_r.ra[0], MA'(0)};
      s_nxt.oe  = s_r.rv[sel] ? ~s_r.rm[sel] : '0;
      if (s_r.act) begin
        if (full || s_r.cnt < blen(s_r.wr)) begin
          beat      = 1'b1;
          s_nxt.cnt = s_r.cnt + 1'b1;
        end else begin
          s_nxt.act = 1'b0;
          if (s_r.ap) begin
            s_nxt.open[s_r.bank] = 1'b0;
          end
        end
      end
      if (!bus.cs_n) begin
        case (cmd)
          CMD_ACT: begin
            s_nxt.open[bus.bank_select] = 1'b1;
            s_nxt.row[bus.bank_select]  = bus.address_bus[ROWW-1:0];
          end
          CMD_RD, CMD_WR: begin
            s_nxt.act   = 1'b1;
            s_nxt.wr    = (cmd == CMD_WR);
            s_nxt.ap    = bus.address_bus[AP_BIT];
            s_nxt.bank  = bus.bank_select;
            s_nxt.start = bus.address_bus[COLW-1:0];
            s_nxt.cnt   = (COLW+1)'(1);
            beat        = 1'b1;
            bw          = (cmd == CMD_WR);
            bbank       = bus.bank_select;
            bcol        = bus.address_bus[COLW-1:0];
          end
          CMD_BST: begin
            stop      = 1'b1;
            s_nxt.act = 1'b0;
          end
          CMD_PRE: begin
            if (bus.address_bus[AP_BIT]) begin
              s_nxt.open = '0;
              stop       = s_r.act;
              s_nxt.act  = 1'b0;
            end else begin
              s_nxt.open[bus.bank_select] = 1'b0;
              if (bus.bank_select == s_r.bank) begin
                stop      = s_r.act;
                s_nxt.act = 1'b0;
              end
            end
          end
          CMD_REF: begin
            if (!bus.cke) begin
              s_nxt.pwr = PWR_SREF;
            end
          end
          CMD_MRS: begin
            s_nxt.mode = bus.address_bus;
          end
          default: begin
          end
        endcase
      end
      if (stop) begin
        beat = 1'b0;
      end
      if (beat && !bw) begin
        s_nxt.rv[0] = 1'b1;
        s_nxt.rm[0] = bus.byte_lane_mask;
        s_nxt.ra[0] = {bbank, s_r.row[bbank], bcol};
      end
    end
  end

  assign bwr   = s_r.cke_q && beat && bw;
  assign baddr = {bbank, s_r.row[bbank], bcol};

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= DEV_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  always_ff @(posedge aclk) begin
    for (int i = 0; i < LANES; i++) begin
      if (bwr && !bus.byte_lane_mask[i]) begin
        mem[baddr][8*i+:8] <= bus.data_bus[8*i+:8];
      end
    end
    if (s_r.cke_q) begin
      dq_r <= mem[s_r.ra[sel]];
    end
  end

  assign bus.dq_d    = dq_r;
  assign bus.dq_d_oe = s_r.oe;
  assign pwr_state   = s_r.pwr;
  assign bank_open   = s_r.open;
endmodule

/* File: logic/qsd_ctl.sv */
// The AXI4-Lite slave port and the address map were decided locally.
module qsd_ctl (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  qsd_if.ctl                         bus,
  input  wire logic                  awvalid,
  output logic                       awready,
  input  wire logic [qsd_pkg::RAW-1:0] awaddr,
  input  wire logic                  wvalid,
  output logic                       wready,
  input  wire logic [31:0]           wdata,
  input  wire logic [3:0]            wstrb,
  output logic                       bvalid,
  input  wire logic                  bready,
  output logic [1:0]                 bresp,
  input  wire logic                  arvalid,
  output logic                       arready,
  input  wire logic [qsd_pkg::RAW-1:0] araddr,
  output logic                       rvalid,
  input  wire logic                  rready,
  output logic [31:0]                rdata,
  output logic [1:0]                 rresp
);
  import qsd_pkg::*;

  typedef struct packed {
    logic             awv;
    logic             wv;
    logic [RAW-1:0]   aa;
    logic [DW-1:0]    wd;
    logic [3:0]       ws;
    logic             awrdy;
    logic             wrdy;
    logic             bv;
    logic [1:0]       br;
    logic             arrdy;
    logic             rv;
    logic [DW-1:0]    rd;
    logic [1:0]       rr;
    logic [DW-1:0]    ctrl;
    logic [DW-1:0]    addr;
    logic [DW-1:0]    rdw;
    logic [7:0]       rcnt;
    qsd_ph_e          ph;
    logic [8:0]       cnt;
    logic [11:0]      tmr;
    logic             pend;
    logic [3:0]       rb;
    logic             cke;
    logic             cs_n;
    qsd_cmd_e         cmd;
    logic [BW-1:0]    ba;
    logic [AW-1:0]    a;
    logic [LANES-1:0] dqm;
    logic [DW-1:0]    dq;
    logic [LANES-1:0] oe;
  } qsd_ctl_s;

  localparam qsd_ctl_s CTL_RST = '{ctrl: CTRL_RST, ph: PH_IDLE, cs_n: 1'b1, cmd: CMD_NOP, cke: 1'b1, default: '0};

  qsd_ctl_s         s_r;
  qsd_ctl_s         s_nxt;
  logic             fin_ready;
  logic             fpush;
  logic             fout_valid;
  logic [DW-1:0]    fout_data;
  logic             wbeat;
  logic             rbeat;
  logic             ok;
  logic             go;
  logic [8:0]       beats;

  function automatic logic [DW-1:0] merge(input logic [DW-1:0] o, input logic [DW-1:0] d,
                                          input logic [3:0] st);
    logic [DW-1:0] r;
    r = o;
    for (int i = 0; i < LANES; i++) begin
      if (st[i]) begin
        r[8*i+:8] = d[8*i+:8];
      end
    end
    return r;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_nxt      = s_r;
    fpush      = 1'b0;
    ok         = 1'b1;
    go         = 1'b0;
    wbeat      = 1'b0;
    rbeat      = 1'b0;
    beats      = (s_r.wd[CM_BEATS+:9] == '0) ? 9'h001 : s_r.wd[CM_BEATS+:9];
    s_nxt.cke  = s_r.ctrl[CT_CKE];
    s_nxt.cs_n = 1'b1;
    s_nxt.cmd  = CMD_NOP;
    s_nxt.oe   = '0;
    s_nxt.dqm  = s_r.ctrl[CT_MASK+:LANES];
    // register bus: write side
    if (awvalid && s_r.awrdy) begin
      s_nxt.awv = 1'b1;
      s_nxt.aa  = awaddr;
    end
    if (wvalid && s_r.wrdy) begin
      s_nxt.wv = 1'b1;
      s_nxt.wd = wdata;
      s_nxt.ws = wstrb;
    end
    if (s_r.bv && bready) begin
      s_nxt.bv  = 1'b0;
      s_nxt.awv = 1'b0;
      s_nxt.wv  = 1'b0;
    end
    if (s_r.awv && s_r.wv && !s_r.bv) begin
      s_nxt.br = RESP_OK;
      case (s_r.aa)
        REG_CTRL:  s_nxt.ctrl = merge(s_r.ctrl, s_r.wd, s_r.ws);
        REG_ADDR:  s_nxt.addr = merge(s_r.addr, s_r.wd, s_r.ws);
        REG_CMD: begin
          ok = (s_r.ph == PH_IDLE) && !s_r.pend;
          go = ok;
        end
        REG_WDATA: begin
          fpush = 1'b1;
          ok    = fin_ready;
        end
        REG_RDATA, REG_STAT: begin
        end
        default:   s_nxt.br = RESP_SLVERR;
      endcase
      s_nxt.bv = ok;
    end
    s_nxt.awrdy = !s_nxt.awv;
    s_nxt.wrdy  = !s_nxt.wv;
    // register bus: read side
    if (s_r.rv && rready) begin
      s_nxt.rv = 1'b0;
    end
    if (arvalid && s_r.arrdy) begin
      s_nxt.rv = 1'b1;
      s_nxt.rr = RESP_OK;
      case (araddr)
        REG_CTRL:  s_nxt.rd = s_r.ctrl;
        REG_ADDR:  s_nxt.rd = s_r.addr;
        REG_RDATA: s_nxt.rd = s_r.rdw;
        REG_STAT:  s_nxt.rd = {16'h0000, s_r.rcnt, 6'h00, s_r.pend, (s_r.ph != PH_IDLE)};
        REG_CMD, REG_WDATA: s_nxt.rd = '0;
        default: begin
          s_nxt.rd = '0;
          s_nxt.rr = RESP_SLVERR;
        end
      endcase
    end
    s_nxt.arrdy = !s_nxt.rv;
    // sequencer
    case (s_r.ph)
      PH_IDLE: begin
        if (s_r.pend && s_r.ctrl[CT_CKE]) begin
          s_nxt.cs_n = 1'b0;
          s_nxt.cmd  = CMD_PRE;
          s_nxt.a    = AW'(1) << AP_BIT;
          s_nxt.ph   = PH_REF;
        end else if (go) begin
          s_nxt.cs_n = 1'b0;
          s_nxt.cmd  = qsd_cmd_e'(s_r.wd[CM_OP+:3]);
          s_nxt.ba   = s_r.addr[AD_BANK+:BW];
          s_nxt.a    = s_r.addr[AW-1:0];
          s_nxt.cnt  = beats - 1'b1;
          wbeat      = (s_nxt.cmd == CMD_WR);
          rbeat      = (s_nxt.cmd == CMD_RD);
          if (beats != 9'h001) begin
            s_nxt.ph = wbeat ? PH_WR : rbeat ? PH_RD : PH_IDLE;
          end
        end
      end
      PH_WR, PH_RD: begin
        wbeat     = (s_r.ph == PH_WR);
        rbeat     = (s_r.ph == PH_RD);
        s_nxt.cnt = s_r.cnt - 1'b1;
        if (s_r.cnt == 9'h001) begin
          s_nxt.ph = PH_IDLE;
        end
      end
      PH_REF: begin
        s_nxt.cs_n = 1'b0;
        s_nxt.cmd  = CMD_REF;
        s_nxt.pend = 1'b0;
        s_nxt.ph   = PH_IDLE;
      end
      default: s_nxt.ph = PH_IDLE;
    endcase
    if (wbeat) begin
      s_nxt.oe  = '1;
      s_nxt.dq  = fout_data;
      s_nxt.dqm = s_r.ctrl[CT_MASK+:LANES] | (fout_valid ? '0 : '1);
    end
    // read capture aligned to latency
    s_nxt.rb = {s_r.rb[2:0], rbeat};
    if (s_r.rb[s_r.ctrl[CT_CL3] ? 3 : 2]) begin
      s_nxt.rdw  = bus.data_bus;
      s_nxt.rcnt = s_r.rcnt + 1'b1;
    end
    // refresh pacing; setting the request wins over its clear
    if (s_r.ctrl[CT_REFEN]) begin
      if (s_r.tmr == 12'(REF_IVL - 1)) begin
        s_nxt.tmr  = '0;
        s_nxt.pend = 1'b1;
      end else begin
        s_nxt.tmr = s_r.tmr + 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= CTL_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  qsd_fifo #(
    .W (DW),
    .D (FIFO_DEPTH)
  ) u_wfifo (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_valid  (fpush),
    .in_ready  (fin_ready),
    .in_data   (s_r.wd),
    .out_valid (fout_valid),
    .out_ready (wbeat),
    .out_data  (fout_data)
  );

  assign awready            = s_r.awrdy;
  assign wready             = s_r.wrdy;
  assign bvalid             = s_r.bv;
  assign bresp              = s_r.br;
  assign arready            = s_r.arrdy;
  assign rvalid             = s_r.rv;
  assign rdata              = s_r.rd;
  assign rresp              = s_r.rr;
  assign bus.cke            = s_r.cke;
  assign bus.cs_n           = s_r.cs_n;
  assign {bus.ras_n, bus.cas_n, bus.we_n} = s_r.cmd;
  assign bus.bank_select    = s_r.ba;
  assign bus.address_bus    = s_r.a;
  assign bus.byte_lane_mask = s_r.dqm;
  assign bus.dq_c           = s_r.dq;
  assign bus.dq_c_oe        = s_r.oe;
endmodule

/* File: verification/qsd_monitor.sv */
module qsd_monitor
  import qsd_pkg::*;
(
  input wire logic             aclk,
  input wire logic             aresetn,
  input wire logic             cke,
  input wire logic             cs_n,
  input wire logic             ras_n,
  input wire logic             cas_n,
  input wire logic             we_n,
  input wire logic [BW-1:0]    bank_select,
  input wire logic [AW-1:0]    address_bus,
  input wire logic [LANES-1:0] byte_lane_mask,
  input wire logic [LANES-1:0] dq_c_oe,
  input wire logic [LANES-1:0] dq_d_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [2:0]    cmd;
  logic [NB-1:0] open_r;
  assign cmd = {ras_n, cas_n, we_n};
  ////////////////////////////////////////////////////////////////
  // rows opened and closed as seen on the pins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      open_r <= '0;
    end else if (!cs_n && cmd == CMD_ACT) begin
      open_r[bank_select] <= 1'b1;
    end else if (!cs_n && cmd == CMD_PRE) begin
      if (address_bus[AP_BIT]) begin
        open_r <= '0;
      end else begin
        open_r[bank_select] <= 1'b0;
      end
    end
  end
  ////////////////////////////////////////////////////////////////
  sequence s_rd;
    !cs_n && cmd == CMD_RD;
  endsequence
  sequence s_two_beats;
    (|dq_d_oe)[*2] ##1 !(|dq_d_oe);
  endsequence
  a_no_bus_fight: assert property (!(|(dq_c_oe & dq_d_oe)))
    else $error("both ends drive one lane");
  a_read_latency: assert property (s_rd |-> ##1 !(|dq_d_oe) ##1 (|dq_d_oe))
    else $error("read data not two cycles after command");
  a_read_burst_len: assert property (s_rd |-> ##2 s_two_beats)
    else $error("read burst not two beats");
  a_write_lanes: assert property (!cs_n && cmd == CMD_WR && byte_lane_mask == 4'h0 |-> dq_c_oe == 4'hF)
    else $error("unmasked write beat not driven");
  a_rw_open_bank: assert property (!cs_n && (cmd == CMD_RD || cmd == CMD_WR) |-> open_r[bank_select])
    else $error("access to closed bank");
  a_cke_freeze: assert property (!cke ##1 1'b1 |=> $stable(dq_d_oe))
    else $error("device moved on invalid edge");
  a_deselect_hold: assert property ((cs_n && !(|dq_d_oe))[*3] |=> !(|dq_d_oe))
    else $error("device drove while deselected");
  a_pall_then_ref: assert property (!cs_n && cmd == CMD_PRE && address_bus[AP_BIT] |=> !cs_n && cmd == CMD_REF)
    else $error("refresh did not follow precharge all");
endmodule

/* File: verification/qsd_tb_top.sv */
module qsd_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import qsd_pkg::*;
  logic          aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic          arvalid, arready, rvalid, rready;
  logic [RAW-1:0] awaddr, araddr;
  logic [31:0]   wdata, rdata, d;
  logic [3:0]    wstrb;
  logic [1:0]    bresp, rresp, r;
  int            miscompares, checks_done, cyc, refs;
  qsd_pwr_e      pwr;
  logic [NB-1:0] bopen;
  qsd_if bus_if();
  qsd_ctl i_qsd_ctl(.aclk(aclk), .aresetn(aresetn), .bus(bus_if), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));
  qsd_dev i_qsd_dev(.aclk(aclk), .aresetn(aresetn), .bus(bus_if), .pwr_state(pwr), .bank_open(bopen));
  qsd_monitor i_qsd_monitor(.aclk(aclk), .aresetn(aresetn), .cke(bus_if.cke), .cs_n(bus_if.cs_n),
    .ras_n(bus_if.ras_n), .cas_n(bus_if.cas_n), .we_n(bus_if.we_n), .bank_select(bus_if.bank_select),
    .address_bus(bus_if.address_bus), .byte_lane_mask(bus_if.byte_lane_mask),
    .dq_c_oe(bus_if.dq_c_oe), .dq_d_oe(bus_if.dq_d_oe));
  ////////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", n, e, g);
      miscompares++;
    end
  endtask
  task automatic axw(input logic [RAW-1:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= v;
    bready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        rs = bresp;
        bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask
  task automatic axr(input logic [RAW-1:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        v = rdata;
        rs = rresp;
        rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask
  task automatic wr(input logic [RAW-1:0] a, input logic [31:0] v);
    logic [1:0] rs;
    axw(a, v, rs);
    chk("bresp", 32'(RESP_OK), 32'(rs));
  endtask
  // issue one pin operation and wait until the controller is idle
  task automatic op(input logic [31:0] c, input logic [31:0] a);
    logic [31:0] s;
    logic [1:0]  rs;
    wr(REG_ADDR, a);
    wr(REG_CMD, c);
    s = 32'h1;
    while (s[ST_BUSY] !== 1'b0) axr(REG_STAT, s, rs);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_reset;
    axr(REG_CTRL, d, r);
    chk("ctrl", CTRL_RST, d);
    axr(6'h3C, d, r);
    chk("rresp", 32'(RESP_SLVERR), 32'(r));
    chk("rdata", 32'h0, d);
    axw(6'h3C, 32'h5A, r);
    chk("bresp", 32'(RESP_SLVERR), 32'(r));
    $display("test reset done");
  endtask
  task automatic t_burst;
    op(32'h0, 32'h21);
    op(32'h3, 32'h1155);
    wr(REG_WDATA, 32'hA5A5_0001);
    wr(REG_WDATA, 32'h5A5A_0002);
    op(32'h24, 32'h1004);
    op(32'h25, 32'h1004);
    axr(REG_RDATA, d, r);
    chk("rdata burst from col4", 32'h5A5A_0002, d);
    op(32'h25, 32'h1005);
    axr(REG_RDATA, d, r);
    chk("rdata burst from col5", 32'hA5A5_0001, d);
    op(32'h3, 32'h0955);
    op(32'h2, 32'h0800);
    op(32'h25, 32'h1004);
    axr(REG_RDATA, d, r);
    chk("rdata other bank", 32'h5A5A_0002, d);
    chk("banks open", 32'h4, 32'(bopen));
    axr(REG_STAT, d, r);
    chk("beats", 32'h6, 32'(d[ST_RCNT+:8]));
    $display("test burst done");
  endtask
  task automatic t_cke;
    wr(REG_CTRL, 32'h0);
    repeat (8) @(posedge aclk);
    chk("power state", 32'(PWR_PDN), 32'(pwr));
    wr(REG_CTRL, 32'h1);
    op(32'h25, 32'h1004);
    axr(REG_RDATA, d, r);
    chk("rdata after gate", 32'h5A5A_0002, d);
    $display("test clock gate done");
  endtask
  task automatic t_mode;
    op(32'h0, 32'h221);
    wr(REG_WDATA, 32'h3C3C_0003);
    op(32'h14, 32'h1004);
    op(32'h25, 32'h1404);
    axr(REG_RDATA, d, r);
    chk("rdata after single write", 32'h5A5A_0002, d);
    chk("banks after auto precharge", 32'h0, 32'(bopen));
    $display("test mode done");
  endtask
  task automatic t_refresh;
    wr(REG_CTRL, 32'h3);
    repeat (REF_IVL + 100) @(posedge aclk);
    axr(REG_STAT, d, r);
    chk("refresh pending", 32'h0, 32'(d[ST_PEND]));
    chk("refresh count", 32'h1, 32'(refs));
    $display("test refresh done");
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (!bus_if.cs_n && {bus_if.ras_n, bus_if.cas_n, bus_if.we_n} == CMD_REF) refs <= refs + 1;
    if (cyc == 20000) begin
      miscompares++;
      summarize();
    end
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_burst();
    t_cke();
    t_mode();
    t_refresh();
    summarize();
  end
endmodule
